// File: test_pattern_pkg.sv
// Constants, register map and pattern codes for the output test-pattern block
//
// Operation
// (R01) Codes 0-3: normal, midscale, ones, zeros, formatted
// (R02) Code 0100 alternates checkerboard words, unformatted
// (R03) Code 1000 alternates user pattern one, two
// (R04) User pattern two: low/high bytes, reset zero
// (R05) Code 0111 alternates all ones, all zeros
// (R06) Codes 0101/0110 long/short pseudo-random, formatted
// (R07) Codes 1001-1100 give fixed unformatted words
// (R08) Tuning bit 6 starts tuning, self clears
// (R09) Limit bits 7:5 accept only 000/011/111
// (R10) Bit 4 selects detector hysteresis, default low
// (R11) Bit 0 selects impedance; register resets 0x61
// (R12) Test code register resets off, next word
`default_nettype none

package test_pattern_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [5:0] IDX_TEST_MODE     = 6'h0D;	// Test code and format select
	localparam logic [5:0] IDX_USER_ONE_LOW  = 6'h19;	// User pattern one, low byte
	localparam logic [5:0] IDX_USER_ONE_HIGH = 6'h1A;	// User pattern one, high byte
	localparam logic [5:0] IDX_USER_TWO_LOW  = 6'h1B;	// User pattern two, low byte
	localparam logic [5:0] IDX_USER_TWO_HIGH = 6'h1C;	// User pattern two, high byte
	localparam logic [5:0] IDX_LOWPASS_TUNE  = 6'h2B;	// Low-pass tuning control
	localparam logic [5:0] IDX_SAT_IMP       = 6'h2C;	// Saturation and impedance

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_TEST_MODE = 8'h00;	// Off, offset binary
	localparam logic [7:0] RST_USER      = 8'h00;	// User pattern bytes
	localparam logic [7:0] RST_TUNE      = 8'h00;	// Tuning idle
	localparam logic [7:0] RST_SAT_IMP   = 8'h61;	// Limit 011, low hyst, high impedance

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TUNE_BIT    = 6;	// Tuning start / busy
	localparam int LIMIT_HI    = 7;	// Limit field top
	localparam int LIMIT_LO    = 5;	// Limit field bottom
	localparam int HYST_BIT    = 4;	// Hysteresis select
	localparam int IMP_BIT     = 0;	// Impedance select
	localparam int TWOS_BIT    = 4;	// Two's complement select in test mode register

	// ****************************************
	// Valid limit codes
	// ****************************************
	localparam logic [2:0] LIMIT_A = 3'h0;
	localparam logic [2:0] LIMIT_B = 3'h3;
	localparam logic [2:0] LIMIT_C = 3'h7;

	// ****************************************
	// Test codes
	// ****************************************
	localparam logic [3:0] TM_OFF      = 4'h0;
	localparam logic [3:0] TM_MID      = 4'h1;
	localparam logic [3:0] TM_PLUS_FS  = 4'h2;
	localparam logic [3:0] TM_MINUS_FS = 4'h3;
	localparam logic [3:0] TM_CHECKER  = 4'h4;
	localparam logic [3:0] TM_PN_LONG  = 4'h5;
	localparam logic [3:0] TM_PN_SHORT = 4'h6;
	localparam logic [3:0] TM_WORD_TOG = 4'h7;
	localparam logic [3:0] TM_USER     = 4'h8;
	localparam logic [3:0] TM_BIT_TOG  = 4'h9;
	localparam logic [3:0] TM_SYNC     = 4'hA;
	localparam logic [3:0] TM_ONE_BIT  = 4'hB;
	localparam logic [3:0] TM_MIXED    = 4'hC;

	// ****************************************
	// Pattern words
	// ****************************************
	localparam logic [11:0] W_MID     = 12'h800;
	localparam logic [11:0] W_ONES    = 12'hFFF;
	localparam logic [11:0] W_ZEROS   = 12'h000;
	localparam logic [11:0] W_CHECK_A = 12'hAAA;
	localparam logic [11:0] W_CHECK_B = 12'h555;
	localparam logic [11:0] W_SYNC    = 12'h03F;
	localparam logic [11:0] W_MIXED   = 12'hA33;

	// ****************************************
	// Pseudo-random generators and tuning time
	// ****************************************
	localparam logic [22:0] PN_LONG_SEED  = 23'h7FFFFF;
	localparam logic [8:0]  PN_SHORT_SEED = 9'h1FF;
	localparam int CLK_HZ       = 20000000;
	localparam int TUNE_TIME_US = 100;	// Assumed tuning duration
	localparam int TUNE_CYCLES  = TUNE_TIME_US * (CLK_HZ / 1000000);

endpackage

`default_nettype wire

// File: test_pattern_gen.sv
// Output test-pattern generator with Wishbone registers and output FIFO
`default_nettype none

// ****************************************
// Word FIFO
// ****************************************
module word_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,	// Push request
	output logic                  in_ready_o,	// Not full
	input  wire logic [WIDTH-1:0] in_data_i,	// Push word
	output logic                  out_valid_o,	// Not empty
	input  wire logic             out_ready_i,	// Pop request
	output logic      [WIDTH-1:0] out_data_o	// Head word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];	// Storage
	logic [AW-1:0]    wr_ptr_r;	// Write index
	logic [AW-1:0]    rd_ptr_r;	// Read index
	logic [AW:0]      count_r;	// Fill level
	logic             push;	// Accepted push
	logic             pop;	// Accepted pop

	assign in_ready_o  = (count_r != DEPTH[AW:0]);
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;

	// Storage write
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data_i;
	end

	// Pointers and level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

// ****************************************
// Top level
// ****************************************
module test_pattern_gen #(
	parameter int FIFO_DEPTH  = 32,
	parameter int TUNE_CYCLES = test_pattern_pkg::TUNE_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Sample input from converter core
	input  wire logic        sample_valid_i,
	output logic             sample_ready_o,
	input  wire logic [11:0] sample_i,
	// Output words to receiver
	output logic             word_valid_o,
	input  wire logic        word_ready_i,
	output logic      [11:0] word_o,
	// Analog settings
	output logic             tune_busy_o,
	output logic      [2:0]  sat_limit_o,
	output logic             sat_hyst_o,
	output logic             input_imp_o
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]  test_mode_r;	// Code and format select
	logic [7:0]  user_one_low_r;	// User pattern one low
	logic [7:0]  user_one_high_r;	// User pattern one high
	logic [7:0]  user_two_low_r;	// User pattern two low
	logic [7:0]  user_two_high_r;	// User pattern two high
	logic        tune_r;	// Tuning in progress
	logic [31:0] tune_cnt_r;	// Tuning timer
	logic [2:0]  sat_limit_r;	// Detector limit
	logic        sat_hyst_r;	// Detector hysteresis
	logic        imp_r;	// Input impedance
	logic        ack_r;	// Bus acknowledge
	logic [31:0] rdata_r;	// Bus read data

	// Datapath state
	logic        phase_r;	// Word 1 / word 2 select
	logic [3:0]  last_code_r;	// Code of the previous word
	logic [22:0] pn_long_r;	// Long generator
	logic [8:0]  pn_short_r;	// Short generator
	logic        out_valid_r;	// Output word held
	logic [11:0] out_word_r;	// Output word

	// Bus decode
	logic [5:0]  idx;	// Register index
	logic        wr_en;	// Write at acknowledge edge
	logic        tune_done;	// Tuning timer expired

	assign idx       = adr_i[7:2];
	assign wr_en     = cyc_i && stb_i && we_i && ack_r && sel_i[0];
	assign tune_done = tune_r && (tune_cnt_r == 32'(TUNE_CYCLES - 1));

	// Acknowledge one cycle after request, dropped after one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= cyc_i && stb_i && !ack_r;
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= 32'h00000000;
		else
		begin
			case (idx)
				test_pattern_pkg::IDX_TEST_MODE:     rdata_r <= {24'h000000, test_mode_r};
				test_pattern_pkg::IDX_USER_ONE_LOW:  rdata_r <= {24'h000000, user_one_low_r};
				test_pattern_pkg::IDX_USER_ONE_HIGH: rdata_r <= {24'h000000, user_one_high_r};
				test_pattern_pkg::IDX_USER_TWO_LOW:  rdata_r <= {24'h000000, user_two_low_r};
				test_pattern_pkg::IDX_USER_TWO_HIGH: rdata_r <= {24'h000000, user_two_high_r};
				test_pattern_pkg::IDX_LOWPASS_TUNE:  rdata_r <= {25'h0000000, tune_r, 6'h00};
				test_pattern_pkg::IDX_SAT_IMP:
					rdata_r <= {24'h000000, sat_limit_r, sat_hyst_r, 3'h0, imp_r};
				default:                             rdata_r <= 32'h00000000;
			endcase
		end
	end

	// Test code register, used from the next generated word on
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			test_mode_r <= test_pattern_pkg::RST_TEST_MODE;	// [R12]
		else if (wr_en && idx == test_pattern_pkg::IDX_TEST_MODE)
			test_mode_r <= {3'h0, dat_i[4:0]};	// [R12]
	end

	// User pattern bytes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			user_one_low_r  <= test_pattern_pkg::RST_USER;
			user_one_high_r <= test_pattern_pkg::RST_USER;
			user_two_low_r  <= test_pattern_pkg::RST_USER;	// [R04]
			user_two_high_r <= test_pattern_pkg::RST_USER;	// [R04]
		end
		else if (wr_en)
		begin
			if (idx == test_pattern_pkg::IDX_USER_ONE_LOW)
				user_one_low_r <= dat_i[7:0];
			if (idx == test_pattern_pkg::IDX_USER_ONE_HIGH)
				user_one_high_r <= dat_i[7:0];
			if (idx == test_pattern_pkg::IDX_USER_TWO_LOW)
				user_two_low_r <= dat_i[7:0];	// [R04]
			if (idx == test_pattern_pkg::IDX_USER_TWO_HIGH)
				user_two_high_r <= dat_i[7:0];	// [R04]
		end
	end

	// Tuning: a one starts the timer, expiry clears the bit; a new start wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tune_r     <= test_pattern_pkg::RST_TUNE[test_pattern_pkg::TUNE_BIT];	// [R08]
			tune_cnt_r <= 32'h00000000;
		end
		else if (wr_en && idx == test_pattern_pkg::IDX_LOWPASS_TUNE && dat_i[test_pattern_pkg::TUNE_BIT])
		begin
			tune_r     <= 1'b1;	// [R08]
			tune_cnt_r <= 32'h00000000;
		end
		else if (tune_done)
		begin
			tune_r     <= 1'b0;	// [R08]
			tune_cnt_r <= 32'h00000000;
		end
		else if (tune_r)
			tune_cnt_r <= tune_cnt_r + 32'h00000001;
	end

	// Saturation and impedance settings; reserved limit codes are ignored
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sat_limit_r <= test_pattern_pkg::RST_SAT_IMP[7:5];	// [R09]
			sat_hyst_r  <= test_pattern_pkg::RST_SAT_IMP[test_pattern_pkg::HYST_BIT];	// [R10]
			imp_r       <= test_pattern_pkg::RST_SAT_IMP[test_pattern_pkg::IMP_BIT];	// [R11]
		end
		else if (wr_en && idx == test_pattern_pkg::IDX_SAT_IMP)
		begin
			if (dat_i[7:5] == test_pattern_pkg::LIMIT_A || dat_i[7:5] == test_pattern_pkg::LIMIT_B
				|| dat_i[7:5] == test_pattern_pkg::LIMIT_C)
				sat_limit_r <= dat_i[7:5];	// [R09]
			sat_hyst_r <= dat_i[test_pattern_pkg::HYST_BIT];	// [R10]
			imp_r      <= dat_i[test_pattern_pkg::IMP_BIT];	// [R11]
		end
	end

	// ****************************************
	// Pattern selection
	// ****************************************
	logic [3:0]  code;	// Current test code
	logic        twos;	// Two's complement output
	logic        push;	// Word accepted by FIFO
	logic        fifo_ready;	// FIFO has room
	logic        fifo_valid;	// FIFO has a word
	logic [11:0] fifo_word;	// FIFO head
	logic        fifo_pop;	// Move head to output
	logic [11:0] raw_word;	// Selected word
	logic        formatted;	// Word takes format conversion
	logic [11:0] gen_word;	// Word pushed into FIFO
	logic        phase;	// Word 2 select for this word

	assign code = test_mode_r[3:0];
	// First word after a code change is always word 1, whatever the old phase was
	assign phase = (code == last_code_r) && phase_r;	// [R02] [R03] [R05]
	assign twos = test_mode_r[test_pattern_pkg::TWOS_BIT];
	assign push = sample_valid_i && fifo_ready;

	// Word select per code
	always_comb
	begin
		raw_word  = sample_i;
		formatted = 1'b1;
		case (code)
			test_pattern_pkg::TM_OFF:      raw_word = sample_i;	// [R01]
			test_pattern_pkg::TM_MID:      raw_word = test_pattern_pkg::W_MID;	// [R01]
			test_pattern_pkg::TM_PLUS_FS:  raw_word = test_pattern_pkg::W_ONES;	// [R01]
			test_pattern_pkg::TM_MINUS_FS: raw_word = test_pattern_pkg::W_ZEROS;	// [R01]
			test_pattern_pkg::TM_CHECKER:
			begin
				raw_word  = phase ? test_pattern_pkg::W_CHECK_B : test_pattern_pkg::W_CHECK_A;	// [R02]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_PN_LONG:  raw_word = pn_long_r[11:0];	// [R06]
			test_pattern_pkg::TM_PN_SHORT: raw_word = {3'h0, pn_short_r};	// [R06]
			test_pattern_pkg::TM_WORD_TOG:
			begin
				raw_word  = phase ? test_pattern_pkg::W_ZEROS : test_pattern_pkg::W_ONES;	// [R05]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_USER:
			begin
				raw_word  = phase ? {user_two_high_r[3:0], user_two_low_r}
				                    : {user_one_high_r[3:0], user_one_low_r};	// [R03]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_BIT_TOG:
			begin
				raw_word  = test_pattern_pkg::W_CHECK_A;	// [R07]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_SYNC:
			begin
				raw_word  = test_pattern_pkg::W_SYNC;	// [R07]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_ONE_BIT:
			begin
				raw_word  = test_pattern_pkg::W_MID;	// [R07]
				formatted = 1'b0;
			end
			test_pattern_pkg::TM_MIXED:
			begin
				raw_word  = test_pattern_pkg::W_MIXED;	// [R07]
				formatted = 1'b0;
			end
			default:                       raw_word = sample_i;
		endcase
	end

	// Format conversion: two's complement flips the top bit
	assign gen_word = (formatted && twos) ? {~raw_word[11], raw_word[10:0]} : raw_word;	// [R01] [R06]

	// Alternation phase; restarts at word 1 when the code changes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phase_r     <= 1'b0;
			last_code_r <= test_pattern_pkg::TM_OFF;
		end
		else if (push)
		begin
			last_code_r <= code;
			phase_r     <= (code != last_code_r) ? 1'b1 : ~phase_r;	// [R02] [R03] [R05]
		end
	end

	// Generators advance per word, reseed when unused
	always_ff @(posedge clk_i)
	begin
		if (rst_i || code != test_pattern_pkg::TM_PN_LONG)
			pn_long_r <= test_pattern_pkg::PN_LONG_SEED;
		else if (push)
			pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[17]};	// [R06]
	end

	// Short generator
	always_ff @(posedge clk_i)
	begin
		if (rst_i || code != test_pattern_pkg::TM_PN_SHORT)
			pn_short_r <= test_pattern_pkg::PN_SHORT_SEED;
		else if (push)
			pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[4]};	// [R06]
	end

	// ****************************************
	// Output buffering
	// ****************************************
	word_fifo #(
		.WIDTH(12),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.in_valid_i (sample_valid_i),
		.in_ready_o (fifo_ready),
		.in_data_i  (gen_word),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o (fifo_word)
	);

	assign fifo_pop = fifo_valid && (!out_valid_r || word_ready_i);

	// Output register toward the receiver
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_valid_r <= 1'b0;
			out_word_r  <= 12'h000;
		end
		else if (fifo_pop)
		begin
			out_valid_r <= 1'b1;
			out_word_r  <= fifo_word;
		end
		else if (word_ready_i)
			out_valid_r <= 1'b0;
	end

	// Back-pressure mirror, registered
	logic ready_r;	// Room flag toward core
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ready_r <= 1'b0;
		else
			ready_r <= fifo_ready;
	end

	assign dat_o          = rdata_r;
	assign ack_o          = ack_r;
	assign sample_ready_o = ready_r;
	assign word_valid_o   = out_valid_r;
	assign word_o         = out_word_r;
	assign tune_busy_o    = tune_r;
	assign sat_limit_o    = sat_limit_r;
	assign sat_hyst_o     = sat_hyst_r;
	assign input_imp_o    = imp_r;
endmodule

`default_nettype wire

// File: tpg_monitor.sv
// Port checker for the output test-pattern block
`default_nettype none

module tpg_monitor #(
	parameter int TUNE_CYCLES = 10
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        word_valid_o,
	input wire logic        word_ready_i,
	input wire logic [11:0] word_o,
	input wire logic        tune_busy_o,
	input wire logic [2:0]  sat_limit_o,
	input wire logic        sat_hyst_o,
	input wire logic        input_imp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Helpers
	// ****************************************
	localparam int TLIM = TUNE_CYCLES + 2;	// Busy ceiling with slack
	int   tune_cnt;	// Busy cycles since last start
	logic tune_wr;	// Accepted write that starts tuning
	assign tune_wr = ack_o && we_i && sel_i[0] && adr_i == 8'hAC && dat_i[6];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s; cyc_i && stb_i && !ack_o; endsequence
	sequence sat_wr_s; ack_o && we_i && sel_i[0] && adr_i == 8'hB0; endsequence
	sequence ack_once_s; ack_o ##1 !ack_o; endsequence
	// Counts busy time, restarted by a new start
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !tune_busy_o || tune_wr)
			tune_cnt <= 0;
		else
			tune_cnt <= tune_cnt + 1;
	end
	// ****************************************
	// Assertions
	// ****************************************
	bus_answer_a: assert property (req_s |=> ack_once_s) else $error("ack not one cycle after request");
	read_width_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
	unmapped_read_a: assert property (ack_o && !we_i && adr_i[7:2] > 6'h2C |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	tune_start_a: assert property (tune_wr |=> tune_busy_o) else $error("tuning did not start");
	tune_bound_a: assert property (tune_cnt <= TLIM) else $error("tuning never cleared");
	word_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
		else $error("word dropped before accept");
	limit_keep_a: assert property (sat_wr_s ##0 !(dat_i[7:5] inside {3'h0, 3'h3, 3'h7}) |=> $stable(sat_limit_o))
		else $error("reserved limit code taken");
	limit_set_a: assert property (sat_wr_s ##0 (dat_i[7:5] inside {3'h0, 3'h3, 3'h7}) |=>
		sat_limit_o == $past(dat_i[7:5])) else $error("valid limit not taken");
	hyst_imp_a: assert property (sat_wr_s |=> {sat_hyst_o, input_imp_o} == {$past(dat_i[4]), $past(dat_i[0])})
		else $error("hysteresis or impedance wrong");
endmodule

bind test_pattern_gen tpg_monitor #(.TUNE_CYCLES(TUNE_CYCLES)) u_tpg_monitor (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .word_o(word_o),
	.tune_busy_o(tune_busy_o), .sat_limit_o(sat_limit_o), .sat_hyst_o(sat_hyst_o), .input_imp_o(input_imp_o));

`default_nettype wire

// File: word_receiver.sv
// Receiver model capturing output words in order
`default_nettype none

module word_receiver (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        stall_i,
	input wire logic        slow_i,
	input wire logic        word_valid_i,
	input wire logic [11:0] word_i,
	output logic            word_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] got [$];	// Captured words, oldest first
	// Takes a word only on a ready edge; slow mode halves the accept rate
	always @(posedge clk_i)
	begin
		if (rst_i)
			word_ready_o <= 1'b0;
		else
		begin
			if (word_valid_i && word_ready_o)
				got.push_back(word_i);
			word_ready_o <= !stall_i && !(slow_i && word_ready_o);
		end
	end
endmodule

`default_nettype wire

// File: test_adc_output_test_patterns.sv
// Self-checking bench for the output test-pattern block
`default_nettype none

module test_adc_output_test_patterns;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Signals and tables
	// ****************************************
	localparam int TUNE = 10;	// Short tuning time
	localparam logic [7:0] RA [6] = '{8'h34, 8'h6C, 8'h70, 8'hAC, 8'hB0, 8'hFC};
	localparam logic [7:0] RV [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h61, 8'h00};
	localparam logic [7:0] MD [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09,
		8'h0A, 8'h0B, 8'h0C, 8'h11, 8'h13, 8'h14, 8'h05, 8'h06};
	localparam logic [11:0] W1 [16] = '{12'h123, 12'h800, 12'hFFF, 12'h000, 12'hAAA, 12'hFFF, 12'h234,
		12'hAAA, 12'h03F, 12'h800, 12'hA33, 12'h000, 12'h800, 12'hAAA, 12'h000, 12'h000};
	localparam logic [11:0] W2 [16] = '{12'h123, 12'h800, 12'hFFF, 12'h000, 12'h555, 12'h000, 12'hBC5,
		12'hAAA, 12'h03F, 12'h800, 12'hA33, 12'h000, 12'h800, 12'h555, 12'h000, 12'h000};
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, sample_valid_i, stall, slow, full;
	logic        ack_o, sample_ready_o, word_valid_o, word_ready_i, tune_busy_o, sat_hyst_o, input_imp_o;
	logic [2:0]  sat_limit_o;
	logic [3:0]  sel_i;
	logic [7:0]  adr_i, rd;
	logic [11:0] sample_i, word_o;
	logic [31:0] dat_i, dat_o;
	int          num_errors, check_count, cycles;

	test_pattern_gen #(.FIFO_DEPTH(32), .TUNE_CYCLES(TUNE)) u_test_pattern_gen (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(sample_i),
		.word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .word_o(word_o), .tune_busy_o(tune_busy_o),
		.sat_limit_o(sat_limit_o), .sat_hyst_o(sat_hyst_o), .input_imp_o(input_imp_o));
	word_receiver u_word_receiver (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
		.word_valid_i(word_valid_o), .word_i(word_o), .word_ready_o(word_ready_i));

	// ****************************************
	// Clock, watchdog and tasks
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Cuts a hang short
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end
	// Compares one value
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One classic bus cycle, held until ack
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Waits until no word arrives for a while
	task automatic settle();
		int idle;
		int last;
		idle = 0;
		last = -1;
		while (idle < 12)
		begin
			@(posedge clk_i);
			idle = (u_word_receiver.got.size() == last) ? idle + 1 : 0;
			last = u_word_receiver.got.size();
		end
	endtask
	// Prints counts and verdict
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, sample_valid_i, stall, slow, full} = 8'h80;
		{adr_i, sel_i, dat_i, sample_i} = '0;
		sel_i = 4'hF;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("reset outputs", {sat_limit_o, sat_hyst_o, input_imp_o}, 5'h0D);
		foreach (RA[i])
		begin
			wb(RA[i], 1'b0, 8'h00, rd);
			check("reset value", rd, RV[i]);
		end
		wb(8'h6C, 1'b1, 8'hC5, rd);
		wb(8'h70, 1'b1, 8'h0B, rd);
		wb(8'h64, 1'b1, 8'h34, rd);
		wb(8'h68, 1'b1, 8'h02, rd);
		wb(8'h6C, 1'b0, 8'h00, rd);
		check("user two low", rd, 8'hC5);
		wb(8'h70, 1'b0, 8'h00, rd);
		check("user two high", rd, 8'h0B);
		// Reserved limit code with other fields changed
		wb(8'hB0, 1'b1, 8'h30, rd);
		check("limit kept", {sat_limit_o, sat_hyst_o, input_imp_o}, 5'h0E);
		wb(8'hB0, 1'b0, 8'h00, rd);
		check("sat reg", rd, 8'h70);
		foreach (RA[i])
		begin
			if (i < 3)
			begin
				wb(8'hB0, 1'b1, {(i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'h3, 5'h01}, rd);
				check("limit set", sat_limit_o, (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'h3);
			end
		end
		// Tuning starts and clears itself
		wb(8'hAC, 1'b1, 8'h40, rd);
		check("tune busy", tune_busy_o, 1'b1);
		wb(8'hAC, 1'b0, 8'h00, rd);
		check("tune read", rd, 8'h40);
		repeat (TUNE + 4) @(posedge clk_i);
		wb(8'hAC, 1'b0, 8'h00, rd);
		check("tune cleared", {tune_busy_o, rd}, 9'h000);
		// Every test code, slow receiver
		slow <= 1'b1;
		foreach (MD[i])
		begin
			wb(8'h34, 1'b1, MD[i], rd);
			u_word_receiver.got.delete();
			// Odd word count so the next code must restart its alternation at word 1
			for (int j = 0; j < 5; j++)
			begin
				sample_valid_i <= 1'b1;
				sample_i <= 12'h123;
				@(posedge clk_i);
			end
			sample_valid_i <= 1'b0;
			settle();
			check("word count", u_word_receiver.got.size(), 5);
			if (i >= 14)
				check("pn moves", u_word_receiver.got[0] !== u_word_receiver.got[1], 1'b1);
			else
				for (int j = 0; j < 5; j++)
					check("pattern", u_word_receiver.got[j], j[0] ? W2[i] : W1[i]);
		end
		// Fill the buffer while stalled, then drain
		wb(8'h34, 1'b1, 8'h00, rd);
		slow <= 1'b0;
		stall <= 1'b1;
		u_word_receiver.got.delete();
		for (int i = 0; i < 40; i++)
		begin
			sample_valid_i <= 1'b1;
			sample_i <= i[11:0];
			@(posedge clk_i);
			if (sample_ready_o === 1'b0)
				full = 1'b1;
		end
		sample_valid_i <= 1'b0;
		stall <= 1'b0;
		check("refused when full", full, 1'b1);
		settle();
		check("fill depth", u_word_receiver.got.size() >= 32, 1'b1);
		foreach (u_word_receiver.got[i])
			check("order", u_word_receiver.got[i], i[11:0]);
		check("drained", word_valid_o, 1'b0);
		complete_run();
	end
endmodule

`default_nettype wire
